// ===== logic/status_output_function_mapper.sv
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "status_output_consts.svh"

module status_output_function_mapper
	import status_output_pkg::*;
#(
	parameter int NUM_OUTPUTS     = 8,
	parameter int ACK_PULSE_CYC   = `ACK_PULSE_MS * 1000 * `CLK_MHZ,
	parameter int MODEM_PULSE_CYC = `MODEM_PULSE_MS * 1000 * `CLK_MHZ
) (
	input  wire logic             ref_clk_in,
	input  wire logic             rst_in,
	input  wire logic [7:0]       addr_in,
	input  wire logic [31:0]      wr_data_in,
	input  wire logic             wr_in,
	input  wire logic             rd_in,
	output logic      [31:0]      rd_data_out,
	input  wire op_mode_t         mode_in,
	input  wire logic             bus_live_in,
	input  wire logic             gen_ok_in,
	input  wire logic             mains_ok_in,
	input  wire logic             mains_par_ok_in,
	input  wire logic             q27_cmd1_in,
	input  wire logic             q27_cmd2_in,
	input  wire logic             par_allowed_in,
	input  wire logic             engine_run_in,
	input  wire logic             supply_delay_done_in,
	input  wire logic             sync_gen_brk_in,
	input  wire logic             sync_mains_brk_in,
	input  wire logic             sync_mg_brk_in,
	input  wire logic             in_sync_in,
	input  wire logic             par_mains_in,
	input  wire logic             par_gensets_in,
	input  wire logic             load_high_in,
	input  wire logic             load_low_in,
	input  wire logic             fault_reset_in,
	input  wire logic             siren_in,
	input  wire logic             stop_key_in,
	input  wire logic             ack_seq_in,
	input  wire logic             modem_seq_in,
	input  wire logic             warn_any_in,
	input  wire logic             unload_any_in,
	input  wire logic             deact_any_in,
	output logic [NUM_OUTPUTS-1:0] func_out
);

	func_code_t                   sel_reg [NUM_OUTPUTS];
	logic       [NUM_OUTPUTS-1:0] func_reg;
	logic       [NUM_OUTPUTS-1:0] func_next;
	logic                         load_hi_reg;
	logic       [31:0]            rd_data_reg;
	logic       [31:0]            rd_data_next;
	logic       [31:0]            ack_cnt_reg;
	logic       [31:0]            modem_cnt_reg;
	logic                         ack_active;
	logic                         modem_active;
	logic                         sync_any;
	logic                         load_cond;

	assign func_out    = func_reg;
	assign rd_data_out = rd_data_reg;

	// shared condition terms
	assign sync_any  = sync_gen_brk_in | sync_mains_brk_in |
		sync_mg_brk_in;
	assign load_cond = load_hi_reg ? load_high_in : load_low_in;

	// control register: high/low load selection
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			load_hi_reg <= `LOAD_HI_RST;
		end else if (wr_in && addr_in == `CTRL_OFS) begin
			load_hi_reg <= wr_data_in[`CTRL_LOAD_HI];
		end
	end

	// acknowledge pulse timer, a retrigger reloads the full length
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ack_cnt_reg <= 32'h0000_0000;
		end else if (ack_seq_in) begin
			ack_cnt_reg <= 32'(ACK_PULSE_CYC);
		end else if (ack_cnt_reg != 32'h0000_0000) begin
			ack_cnt_reg <= ack_cnt_reg - 32'h0000_0001;
		end
	end

	// modem reset pulse timer, same scheme, twice as long
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			modem_cnt_reg <= 32'h0000_0000;
		end else if (modem_seq_in) begin
			modem_cnt_reg <= 32'(MODEM_PULSE_CYC);
		end else if (modem_cnt_reg != 32'h0000_0000) begin
			modem_cnt_reg <= modem_cnt_reg - 32'h0000_0001;
		end
	end

	assign ack_active   = ack_cnt_reg != 32'h0000_0000;
	assign modem_active = modem_cnt_reg != 32'h0000_0000;

	// one selector register and one output per channel
	for (genvar i = 0; i < NUM_OUTPUTS; i++) begin : g_chan
		localparam logic [7:0] SEL_ADDR = 8'(`SEL_BASE + 4 * i);

		// function selector, written by software
		always_ff @(posedge ref_clk_in or posedge rst_in) begin
			if (rst_in) begin
				sel_reg[i] <= `FC_NONE;
			end else if (wr_in && addr_in == SEL_ADDR) begin
				sel_reg[i] <= wr_data_in[15:0];
			end
		end

		// condition chosen by the selector; unknown codes stay low
		always_comb begin
			case (sel_reg[i])
				`FC_REMOTE:     func_next[i] = mode_in == MODE_REMOTE;
				`FC_NOT_OFF:    func_next[i] = mode_in != MODE_OFF;
				`FC_AUTO_ANY:   func_next[i] = mode_in == MODE_AUTO ||
					mode_in == MODE_TEST ||
					mode_in == MODE_REMOTE;
				`FC_BUS_LIVE:   func_next[i] = bus_live_in;
				`FC_GEN_OK:     func_next[i] = gen_ok_in;
				`FC_MAINS_OK:   func_next[i] = mains_ok_in;
				`FC_MAINS_PAR:  func_next[i] = mains_par_ok_in;
				`FC_Q27_CMD1:   func_next[i] = q27_cmd1_in;
				`FC_Q27_CMD2:   func_next[i] = q27_cmd2_in;
				`FC_PAR_ALLOW:  func_next[i] = par_allowed_in;
				`FC_ENG_RUN:    func_next[i] = engine_run_in;
				`FC_SUPPLY:     func_next[i] = engine_run_in &
					supply_delay_done_in;
				`FC_SYNC_GEN:   func_next[i] = sync_gen_brk_in;
				`FC_SYNC_MAINS: func_next[i] = sync_mains_brk_in |
					sync_mg_brk_in;
				`FC_SYNC_ANY:   func_next[i] = sync_any;
				`FC_SYNC_OK:    func_next[i] = sync_any & in_sync_in;
				`FC_PAR_MAINS:  func_next[i] = par_mains_in;
				`FC_PAR_GENS:   func_next[i] = par_gensets_in &
					~par_mains_in;
				`FC_LOAD:       func_next[i] = load_cond;
				`FC_FLT_RESET:  func_next[i] = fault_reset_in;
				`FC_SIREN:      func_next[i] = siren_in;
				`FC_LAMP_TEST:  func_next[i] = mode_in == MODE_OFF &&
					stop_key_in;
				`FC_ACK_PULSE:  func_next[i] = ack_active;
				`FC_MODEM_RST:  func_next[i] = modem_active;
				`FC_WARN:       func_next[i] = warn_any_in;
				`FC_UNLOAD:     func_next[i] = unload_any_in;
				`FC_DEACT:      func_next[i] = deact_any_in;
				default:        func_next[i] = 1'b0;
			endcase
		end

		// registered output so relays never see decode glitches
		always_ff @(posedge ref_clk_in or posedge rst_in) begin
			if (rst_in) begin
				func_reg[i] <= 1'b0;
			end else begin
				func_reg[i] <= func_next[i];
			end
		end

		property p_remote;
			@(posedge ref_clk_in) disable iff (rst_in)
			sel_reg[i] == `FC_REMOTE |=>
				func_reg[i] == $past(mode_in == MODE_REMOTE);
		endproperty
		a_remote: assert property (p_remote)
			else $error("remote start output wrong");

		property p_not_off;
			@(posedge ref_clk_in) disable iff (rst_in)
			sel_reg[i] == `FC_NOT_OFF && mode_in == MODE_OFF |=>
				!func_reg[i];
		endproperty
		a_not_off: assert property (p_not_off)
			else $error("not-off output high in off mode");

		property p_auto_any;
			@(posedge ref_clk_in) disable iff (rst_in)
			sel_reg[i] == `FC_AUTO_ANY && mode_in == MODE_TEST |=>
				func_reg[i];
		endproperty
		a_auto_any: assert property (p_auto_any)
			else $error("automatic-class output low in test");

		property p_supply;
			@(posedge ref_clk_in) disable iff (rst_in)
			sel_reg[i] == `FC_SUPPLY |=> func_reg[i] ==
				$past(engine_run_in && supply_delay_done_in);
		endproperty
		a_supply: assert property (p_supply)
			else $error("supply output wrong");

		property p_sync_ok;
			@(posedge ref_clk_in) disable iff (rst_in)
			sel_reg[i] == `FC_SYNC_OK && !in_sync_in |=> !func_reg[i];
		endproperty
		a_sync_ok: assert property (p_sync_ok)
			else $error("synchronised output high while not in sync");

		property p_par_gens;
			@(posedge ref_clk_in) disable iff (rst_in)
			sel_reg[i] == `FC_PAR_GENS && par_mains_in |=> !func_reg[i];
		endproperty
		a_par_gens: assert property (p_par_gens)
			else $error("gensets-only output high with mains parallel");

		property p_lamp;
			@(posedge ref_clk_in) disable iff (rst_in)
			sel_reg[i] == `FC_LAMP_TEST |=> func_reg[i] ==
				$past(mode_in == MODE_OFF && stop_key_in);
		endproperty
		a_lamp: assert property (p_lamp)
			else $error("lamp test output wrong");

		property p_warn;
			@(posedge ref_clk_in) disable iff (rst_in)
			sel_reg[i] == `FC_WARN |=> func_reg[i] == $past(warn_any_in);
		endproperty
		a_warn: assert property (p_warn)
			else $error("warning output wrong");

		property p_siren;
			@(posedge ref_clk_in) disable iff (rst_in)
			sel_reg[i] == `FC_SIREN |=> func_reg[i] == $past(siren_in);
		endproperty
		a_siren: assert property (p_siren)
			else $error("siren output does not follow siren");

		property p_sync_mains;
			@(posedge ref_clk_in) disable iff (rst_in)
			sel_reg[i] == `FC_SYNC_MAINS |=> func_reg[i] ==
				$past(sync_mains_brk_in || sync_mg_brk_in);
		endproperty
		a_sync_mains: assert property (p_sync_mains)
			else $error("mains breaker sync output wrong");

		property p_unknown;
			@(posedge ref_clk_in) disable iff (rst_in)
			sel_reg[i] == `FC_NONE |=> !func_reg[i];
		endproperty
		a_unknown: assert property (p_unknown)
			else $error("unassigned output went high");

		property p_ack_out;
			@(posedge ref_clk_in) disable iff (rst_in)
			sel_reg[i] == `FC_ACK_PULSE && ack_seq_in |=>
				##1 func_reg[i];
		endproperty
		a_ack_out: assert property (p_ack_out)
			else $error("acknowledge output missing after trigger");
	end

	// register read mux, answer is registered one cycle later
	always_comb begin
		rd_data_next = 32'h0000_0000;
		if (addr_in == `STATUS_OFS) begin
			rd_data_next[NUM_OUTPUTS-1:0] = func_reg;
		end else if (addr_in == `CTRL_OFS) begin
			rd_data_next[`CTRL_LOAD_HI] = load_hi_reg;
		end
		for (int k = 0; k < NUM_OUTPUTS; k++) begin
			if (addr_in == 8'(`SEL_BASE + 4 * k)) begin
				rd_data_next[15:0] = sel_reg[k];
			end
		end
	end

	// data stand only in the cycle after the strobe
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_data_reg <= 32'h0000_0000;
		end else if (rd_in) begin
			rd_data_reg <= rd_data_next;
		end else begin
			rd_data_reg <= 32'h0000_0000;
		end
	end

	property p_ack_load;
		@(posedge ref_clk_in) disable iff (rst_in)
		ack_seq_in |=> ack_cnt_reg == 32'(ACK_PULSE_CYC);
	endproperty
	a_ack_load: assert property (p_ack_load)
		else $error("acknowledge timer not reloaded");

	property p_ack_count;
		@(posedge ref_clk_in) disable iff (rst_in)
		ack_active && !ack_seq_in |=>
			ack_cnt_reg == $past(ack_cnt_reg) - 32'h0000_0001;
	endproperty
	a_ack_count: assert property (p_ack_count)
		else $error("acknowledge timer did not count down");

	property p_modem_load;
		@(posedge ref_clk_in) disable iff (rst_in)
		modem_seq_in |=> modem_cnt_reg == 32'(MODEM_PULSE_CYC);
	endproperty
	a_modem_load: assert property (p_modem_load)
		else $error("modem timer not reloaded");

	property p_modem_idle;
		@(posedge ref_clk_in) disable iff (rst_in)
		!modem_active && !modem_seq_in |=> !modem_active;
	endproperty
	a_modem_idle: assert property (p_modem_idle)
		else $error("modem pulse started without trigger");

	// a stuck counter would stretch the relay pulse forever
	property p_modem_count;
		@(posedge ref_clk_in) disable iff (rst_in)
		modem_active && !modem_seq_in |=>
			modem_cnt_reg == $past(modem_cnt_reg) - 32'h0000_0001;
	endproperty
	a_modem_count: assert property (p_modem_count)
		else $error("modem timer did not count down");

	property p_ack_idle;
		@(posedge ref_clk_in) disable iff (rst_in)
		!ack_active && !ack_seq_in |=> !ack_active;
	endproperty
	a_ack_idle: assert property (p_ack_idle)
		else $error("acknowledge pulse started without trigger");

	property p_rd_idle;
		@(posedge ref_clk_in) disable iff (rst_in)
		!rd_in |=> rd_data_out == 32'h0000_0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside answer cycle");

	property p_cov_ack_end;
		@(posedge ref_clk_in) disable iff (rst_in)
		ack_active ##1 !ack_active;
	endproperty
	c_ack_end: cover property (p_cov_ack_end);

	property p_cov_modem;
		@(posedge ref_clk_in) disable iff (rst_in)
		modem_seq_in ##1 modem_active;
	endproperty
	c_modem: cover property (p_cov_modem);

	property p_cov_remote;
		@(posedge ref_clk_in) disable iff (rst_in)
		sel_reg[0] == `FC_REMOTE && func_reg[0];
	endproperty
	c_remote: cover property (p_cov_remote);

	property p_cov_retrig;
		@(posedge ref_clk_in) disable iff (rst_in)
		ack_active && ack_seq_in;
	endproperty
	c_retrig: cover property (p_cov_retrig);

endmodule : status_output_function_mapper

// ===== common/status_output_consts.svh
// How it works
// - remote-start mode drives its output
// - any mode other than off/reset (manual, automatic, test, remote start) drives output
// - automatic, test or remote start drives output
// - voltage on parallel bars drives output
// - generator inside normal window drives output
// - mains inside presence window drives output
// - output drops on mains anomaly demanding break
// - two outputs carry both 27Q commands
// - mains status permitting parallel drives output
// - engine running, even manually started, drives output
// - engine running and supply delay elapsed
// - synchronising for generator breaker drives output
// - synchronising for mains or mains-genset breaker
// - synchronising for any breaker drives output
// - any synchronising while actually synchronous
// - parallel with mains; with gensets only
// - high or low load, configuration selects
// - fault reset mode drives output
// - output follows internal siren
// - off/reset mode with stop key: lamp test
// - acknowledge sequence gives one-second pulse
// - modem reset sequence gives two-second pulse
// - warnings, unloads, deactivations drive three outputs
`ifndef STATUS_OUTPUT_CONSTS_SVH
`define STATUS_OUTPUT_CONSTS_SVH

// function codes, decimal value in the comment
`define FC_NONE       16'h0000
`define FC_REMOTE     16'h0bbd // 3005
`define FC_NOT_OFF    16'h0bc3 // 3011
`define FC_AUTO_ANY   16'h0bc4 // 3012
`define FC_BUS_LIVE   16'h0bd7 // 3031
`define FC_GEN_OK     16'h0bd8 // 3032
`define FC_MAINS_OK   16'h0bd9 // 3033
`define FC_MAINS_PAR  16'h0bda // 3034
`define FC_Q27_CMD1   16'h0bdb // 3035
`define FC_Q27_CMD2   16'h0bdc // 3036
`define FC_PAR_ALLOW  16'h0bdd // 3037
`define FC_ENG_RUN    16'h0bf5 // 3061
`define FC_SUPPLY     16'h0bf6 // 3062
`define FC_SYNC_GEN   16'h0c13 // 3091
`define FC_SYNC_MAINS 16'h0c14 // 3092
`define FC_SYNC_ANY   16'h0c15 // 3093
`define FC_SYNC_OK    16'h0c16 // 3094
`define FC_PAR_MAINS  16'h0c17 // 3095
`define FC_PAR_GENS   16'h0c18 // 3096
`define FC_LOAD       16'h0c31 // 3121
`define FC_FLT_RESET  16'h0c4f // 3151
`define FC_SIREN      16'h0c50 // 3152
`define FC_LAMP_TEST  16'h0c51 // 3153
`define FC_ACK_PULSE  16'h0c52 // 3154
`define FC_MODEM_RST  16'h0c53 // 3155
`define FC_WARN       16'h0fa1 // 4001
`define FC_UNLOAD     16'h0fa2 // 4002
`define FC_DEACT      16'h0fa3 // 4003

// register map, byte addresses
`define SEL_BASE      8'h00
`define STATUS_OFS    8'h40
`define CTRL_OFS      8'h44
`define CTRL_LOAD_HI  0
`define LOAD_HI_RST   1'b1

// timing
`define CLK_MHZ       250
`define ACK_PULSE_MS  1000
`define MODEM_PULSE_MS 2000

`endif

// ===== common/status_output_pkg.sv
package status_output_pkg;

	typedef logic [15:0] func_code_t;

	// controller operating mode as reported by the mode logic
	typedef enum logic [2:0] {
		MODE_OFF    = 3'h0,
		MODE_MAN    = 3'h1,
		MODE_AUTO   = 3'h2,
		MODE_TEST   = 3'h3,
		MODE_REMOTE = 3'h4
	} op_mode_t;

endpackage : status_output_pkg

// ===== verif/status_output_relay_model.sv
`timescale 1ns/1ps
// external relay bank: each contact closes one clock after its coil,
// so a glitch-free output is all that reaches the lamps
module status_output_relay_model #(
	parameter int N = 8
) (
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	input  wire logic [N-1:0] coil_in,
	output logic      [N-1:0] contact_out
);
	// contacts drop while the controller sits in reset
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in)
			contact_out <= '0;
		else
			contact_out <= coil_in;
	end
endmodule : status_output_relay_model

// ===== verif/tb_status_output_function_mapper.sv
`timescale 1ns/1ps
`include "status_output_consts.svh"
module tb_status_output_function_mapper
	import status_output_pkg::*;
;
	localparam int ACK_N = 20;
	localparam int MDM_N = 40;
	logic        ref_clk_in;
	logic        rst_in;
	logic [7:0]  addr_in;
	logic [31:0] wr_data_in;
	logic        wr_in;
	logic        rd_in;
	logic [31:0] rd_data_out;
	logic [7:0]  func_out;
	logic [7:0]  relay;
	logic [22:0] cv;
	logic [1:0]  trg;
	op_mode_t    md;
	logic        lh;
	logic [31:0] d;
	logic [7:0]  ev;
	func_code_t  sel_v [8];
	integer      seed = 32'hc20f3b4f;
	int          fail_count = 0;
	int          n_tests = 0;
	int          hi;
	// known codes, idle and a few unmapped ones
	func_code_t codes [32] = '{`FC_REMOTE, `FC_NOT_OFF, `FC_AUTO_ANY,
		`FC_BUS_LIVE, `FC_GEN_OK, `FC_MAINS_OK, `FC_MAINS_PAR, `FC_Q27_CMD1,
		`FC_Q27_CMD2, `FC_PAR_ALLOW, `FC_ENG_RUN, `FC_SUPPLY, `FC_SYNC_GEN,
		`FC_SYNC_MAINS, `FC_SYNC_ANY, `FC_SYNC_OK, `FC_PAR_MAINS,
		`FC_PAR_GENS, `FC_LOAD, `FC_FLT_RESET, `FC_SIREN, `FC_LAMP_TEST,
		`FC_ACK_PULSE, `FC_MODEM_RST, `FC_WARN, `FC_UNLOAD, `FC_DEACT,
		`FC_NONE, 16'h0bbe, 16'h0fa4, 16'hffff, 16'h0c54};

	status_output_function_mapper #(
		.NUM_OUTPUTS(8), .ACK_PULSE_CYC(ACK_N), .MODEM_PULSE_CYC(MDM_N)
	) dut (
		.ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in),
		.wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
		.rd_data_out(rd_data_out), .mode_in(md), .bus_live_in(cv[0]),
		.gen_ok_in(cv[1]), .mains_ok_in(cv[2]), .mains_par_ok_in(cv[3]),
		.q27_cmd1_in(cv[4]), .q27_cmd2_in(cv[5]), .par_allowed_in(cv[6]),
		.engine_run_in(cv[7]), .supply_delay_done_in(cv[8]),
		.sync_gen_brk_in(cv[9]), .sync_mains_brk_in(cv[10]),
		.sync_mg_brk_in(cv[11]), .in_sync_in(cv[12]),
		.par_mains_in(cv[13]), .par_gensets_in(cv[14]),
		.load_high_in(cv[15]), .load_low_in(cv[16]),
		.fault_reset_in(cv[17]), .siren_in(cv[18]), .stop_key_in(cv[19]),
		.ack_seq_in(trg[0]), .modem_seq_in(trg[1]), .warn_any_in(cv[20]),
		.unload_any_in(cv[21]), .deact_any_in(cv[22]), .func_out(func_out)
	);
	status_output_relay_model #(.N(8)) relays (.clk_in(ref_clk_in),
		.rst_in(rst_in), .coil_in(func_out), .contact_out(relay));

	// 250 MHz
	initial begin
		ref_clk_in = 1'b0;
		forever #2 ref_clk_in = ~ref_clk_in;
	end

	// expected level of one output from the held condition inputs
	function automatic logic exp_fc(func_code_t fc, op_mode_t m,
		logic [22:0] v, logic l);
		case (fc)
		`FC_REMOTE:     return m == MODE_REMOTE;
		`FC_NOT_OFF:    return m != MODE_OFF;
		`FC_AUTO_ANY:   return m inside {MODE_AUTO, MODE_TEST, MODE_REMOTE};
		`FC_BUS_LIVE:   return v[0];
		`FC_GEN_OK:     return v[1];
		`FC_MAINS_OK:   return v[2];
		`FC_MAINS_PAR:  return v[3];
		`FC_Q27_CMD1:   return v[4];
		`FC_Q27_CMD2:   return v[5];
		`FC_PAR_ALLOW:  return v[6];
		`FC_ENG_RUN:    return v[7];
		`FC_SUPPLY:     return v[7] & v[8];
		`FC_SYNC_GEN:   return v[9];
		`FC_SYNC_MAINS: return v[10] | v[11];
		`FC_SYNC_ANY:   return |v[11:9];
		`FC_SYNC_OK:    return (|v[11:9]) & v[12];
		`FC_PAR_MAINS:  return v[13];
		`FC_PAR_GENS:   return v[14] & ~v[13];
		`FC_LOAD:       return l ? v[15] : v[16];
		`FC_FLT_RESET:  return v[17];
		`FC_SIREN:      return v[18];
		`FC_LAMP_TEST:  return m == MODE_OFF && v[19];
		`FC_WARN:       return v[20];
		`FC_UNLOAD:     return v[21];
		`FC_DEACT:      return v[22];
		default:        return 1'b0; // idle pulses and unknown codes
		endcase
	endfunction : exp_fc

	task automatic chk(input string n, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", n, e, g);
			fail_count++;
		end
	endtask : chk

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk_in);
		addr_in <= a;
		wr_data_in <= v;
		wr_in <= 1'b1;
		@(posedge ref_clk_in);
		wr_in <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		@(posedge ref_clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge ref_clk_in);
		rd_in <= 1'b0;
		#1 v = rd_data_out;
	endtask : rd_reg

	task automatic hold(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask : hold

	// one trigger, optionally a second after gap cycles; counts high cycles
	task automatic pulse_run(input int w, input int gap, output int h);
		h = 0;
		for (int c = 0; c < 120; c++) begin
			@(posedge ref_clk_in);
			trg <= (c == 0 || c == gap) ? 2'(1 << w) : 2'b00;
			#1;
			if (func_out[w] === 1'b1)
				h++;
		end
	endtask : pulse_run

	task automatic results;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results

	// hang guard
	initial begin
		#400000;
		fail_count++;
		results();
	end

	initial begin
		rst_in = 1'b1;
		{addr_in, wr_data_in, wr_in, rd_in, cv, trg, lh} = '0;
		md = MODE_OFF;
		hold(4);
		chk("func_out_rst", 32'h0, 32'(func_out));
		rst_in <= 1'b0;
		rd_reg(`CTRL_OFS, d);
		chk("ctrl_rst", 32'h1, d);
		wr_reg(`SEL_BASE, 32'habcd0bbd);
		rd_reg(`SEL_BASE, d);
		chk("sel_upper", 32'h00000bbd, d);
		rd_reg(8'h80, d);
		chk("unmapped", 32'h0, d);
		$display("test registers done");
		// each code is used once over the four rounds
		for (int r = 0; r < 4; r++) begin
			for (int i = 0; i < 8; i++) begin
				sel_v[i] = codes[((r * 3 + i) % 4) * 8 + i];
				wr_reg(8'(4 * i), 32'(sel_v[i]));
			end
			lh = 1'($random(seed));
			wr_reg(`CTRL_OFS, 32'(lh));
			for (int s = 0; s < 25; s++) begin
				// flip the load select mid-round so both choices are seen
				if (s == 12) begin
					lh = ~lh;
					wr_reg(`CTRL_OFS, 32'(lh));
				end
				@(posedge ref_clk_in);
				if (s < 3) begin
					cv <= (s == 0) ? '0 : '1;
					md <= (s == 2) ? MODE_OFF : MODE_REMOTE;
				end else begin
					cv <= 23'($random(seed));
					md <= op_mode_t'(3'($unsigned($random(seed)) % 5));
				end
				hold(3);
				for (int i = 0; i < 8; i++)
					ev[i] = exp_fc(sel_v[i], md, cv, lh);
				chk("func_out", 32'(ev), 32'(func_out));
				chk("relay", 32'(ev), 32'(relay));
				if (s % 6 == 0) begin
					rd_reg(`STATUS_OFS, d);
					chk("status", 32'(ev), d);
				end
			end
		end
		$display("test functions done");
		wr_reg(`SEL_BASE, 32'(`FC_ACK_PULSE));
		wr_reg(`SEL_BASE + 8'h04, 32'(`FC_MODEM_RST));
		pulse_run(0, 0, hi);
		chk("ack_len", ACK_N, hi);
		pulse_run(0, 19, hi);
		chk("ack_retrig", ACK_N + 19, hi);
		pulse_run(1, 0, hi);
		chk("modem_len", MDM_N, hi);
		pulse_run(1, 25, hi);
		chk("modem_retrig", MDM_N + 25, hi);
		$display("test pulses done");
		wr_reg(`SEL_BASE + 8'h08, 32'(`FC_REMOTE));
		@(posedge ref_clk_in);
		cv <= '1;
		md <= MODE_REMOTE;
		hold(3);
		chk("pre_reset", 32'h1, 32'(func_out[2]));
		rst_in <= 1'b1;
		#1;
		chk("in_reset", 32'h0, 32'(func_out));
		hold(2);
		rst_in <= 1'b0;
		hold(2);
		chk("after_reset", 32'h0, 32'(func_out));
		rd_reg(`SEL_BASE + 8'h08, d);
		chk("sel_cleared", 32'h0, d);
		$display("test reset done");
		results();
	end
endmodule : tb_status_output_function_mapper
